// *** host_bridge_consts.svh ***
`ifndef HOST_BRIDGE_CONSTS_SVH
`define HOST_BRIDGE_CONSTS_SVH
`define CMD_DATA_ADDR 16'h1400
`define CMD_STATUS_ADDR 16'h1800
`define STATUS_PENDING_BIT 0
`define DMA_WINDOW_BIT 15
`define ROM_FIRST 16'h0000
`define ROM_LAST 16'h07FF
`define RAM_FIRST 16'h0800
`define RAM_LAST 16'h09FF
`define SEL_A_FIRST 16'h0C00
`define SEL_A_LAST 16'h0FFF
`define SEL_B_FIRST 16'h1000
`define SEL_B_LAST 16'h13FF
`define SEL_C_FIRST 16'h1C00
`define SEL_C_LAST 16'h1FFF
`define CMD_FIFO_DEPTH 8
`define BYTE_RESET 8'h00
`endif

// *** host_bridge_pkg.sv ***
package host_bridge_pkg;
  typedef enum logic [1:0] {
    dma_idle,
    dma_request,
    dma_transfer,
    dma_finish
  } dma_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic write;
  } dma_access_t;

  typedef struct packed {
    logic rom;
    logic ram;
    logic ext_a;
    logic ext_b;
    logic ext_c;
  } local_selects_t;
endpackage : host_bridge_pkg

// *** host_command_port_dma_window.sv ***
`timescale 1ns/1ps
`include "host_bridge_consts.svh"

module command_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic full;
  logic empty;

  assign full = (count == FULL_COUNT);
  assign empty = (count == '0);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = store[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage has no reset; the pointers and the count alone say which entries are valid.
  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
    end
  end

  // A push and a pop in one cycle leave the count alone, so no byte is lost.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end
endmodule : command_fifo

module host_command_port_dma_window
  import host_bridge_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] port_jumper,
  input wire logic host_io_write,
  input wire logic [7:0] host_io_addr,
  input wire logic [7:0] host_data_out,
  output logic host_cmd_ready,
  output logic host_hold_req,
  input wire logic host_hold_ack,
  input wire logic priority_chain_in,
  output logic priority_chain_out,
  output logic [15:0] dma_addr,
  output logic [7:0] dma_wdata,
  output logic dma_data_oe,
  output logic dma_read,
  output logic dma_write,
  input wire logic dma_done,
  input wire logic [7:0] dma_rdata,
  input wire logic upper_window_force,
  input wire logic [15:0] local_addr,
  input wire logic local_rd,
  input wire logic local_wr,
  input wire logic local_fetch,
  input wire logic [7:0] local_wdata,
  input wire logic local_io_cycle,
  output logic [7:0] local_rdata,
  output logic local_rvalid,
  output logic local_wait,
  output logic rom_select,
  output logic ram_select,
  output logic ext_select_a,
  output logic ext_select_b,
  output logic ext_select_c,
  output logic io_fault
);
  dma_state_t dma_state;
  dma_access_t dma_req;
  local_selects_t sel;
  logic cmd_write;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic cmd_pop;
  logic [7:0] last_cmd;
  logic local_access;
  logic window_hit;
  logic dma_start;
  logic dma_owns_bus;
  logic dma_grant;
  logic dma_complete;
  logic cmd_hold;
  logic dma_hold;
  logic local_read;
  logic [7:0] next_rdata;
  logic [4:0] range_hit;

  localparam logic [15:0] RANGE_FIRST [5] = '{
    `ROM_FIRST,
    `RAM_FIRST,
    `SEL_A_FIRST,
    `SEL_B_FIRST,
    `SEL_C_FIRST
  };
  localparam logic [15:0] RANGE_LAST [5] = '{
    `ROM_LAST,
    `RAM_LAST,
    `SEL_A_LAST,
    `SEL_B_LAST,
    `SEL_C_LAST
  };

  // The jumper pattern is the port address directly.
  assign cmd_write = host_io_write && (host_io_addr == port_jumper);
  // An instruction fetch is served exactly like a data read of the same address.
  assign local_read = local_rd || local_fetch;
  assign local_access = local_read || local_wr;
  assign window_hit = local_addr[`DMA_WINDOW_BIT];
  // A window access starts a host cycle only from idle; a strobe still held when the state returns to idle starts another.
  assign dma_start = local_access && window_hit && (dma_state == dma_idle);
  assign cmd_pop = local_read && (local_addr == `CMD_DATA_ADDR) && cmd_valid;

  // Host bytes queue here until the local processor takes them in order.
  command_fifo #(
    .WIDTH(8),
    .DEPTH(`CMD_FIFO_DEPTH)
  ) cmd_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(cmd_write),
    .in_ready(host_cmd_ready),
    .in_data(host_data_out),
    .out_valid(cmd_valid),
    .out_ready(cmd_pop),
    .out_data(cmd_byte)
  );

  // The host stays held while any command awaits the local read.
  assign dma_owns_bus = (dma_state == dma_request) || (dma_state == dma_transfer);
  assign cmd_hold = cmd_valid;
  // A board raises its DMA hold only while no board higher in the chain owns the bus; the command hold ignores the chain.
  assign dma_hold = dma_owns_bus && priority_chain_in;
  assign host_hold_req = cmd_hold || dma_hold;
  assign priority_chain_out = priority_chain_in && !dma_owns_bus;
  assign dma_grant = host_hold_ack && priority_chain_in;
  assign dma_complete = (dma_state == dma_transfer) && dma_done;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dma_state <= dma_idle;
    end else begin
      unique case (dma_state)
        dma_idle: begin
          if (dma_start) begin
            dma_state <= dma_request;
          end
        end
        // The request waits for the host's grant with the chain still open to this board.
        dma_request: begin
          if (dma_grant) begin
            dma_state <= dma_transfer;
          end
        end
        // One byte moves per grant; the host runs again once the cycle is done unless a command is still queued.
        dma_transfer: begin
          if (dma_done) begin
            dma_state <= dma_finish;
          end
        end
        dma_finish: begin
          dma_state <= dma_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dma_req <= '0;
    end else if (dma_start) begin
      dma_req.addr <= {upper_window_force, local_addr[14:0]};
      dma_req.wdata <= local_wdata;
      dma_req.write <= local_wr;
    end
  end

  assign dma_addr = dma_req.addr;
  assign dma_wdata = dma_req.wdata;
  // The data bus is driven only in a write cycle, so a host read never meets a clash.
  always_comb begin
    dma_read = 1'b0;
    dma_write = 1'b0;
    dma_data_oe = 1'b0;
    if (dma_state == dma_transfer) begin
      dma_read = !dma_req.write;
      dma_write = dma_req.write;
      dma_data_oe = dma_req.write;
    end
  end
  // Fetches are served like data reads through the window.
  assign local_wait = (dma_state != dma_idle) || dma_start;

  // The last byte taken is kept, so a read of an empty queue changes nothing.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      last_cmd <= `BYTE_RESET;
    end else if (cmd_pop) begin
      last_cmd <= cmd_byte;
    end
  end

  // A command read gives the oldest queued byte, or the last one taken when none waits.
  always_comb begin
    next_rdata = `BYTE_RESET;
    if (local_addr == `CMD_DATA_ADDR) begin
      next_rdata = cmd_valid ? cmd_byte : last_cmd;
    end else if (local_addr == `CMD_STATUS_ADDR) begin
      next_rdata[`STATUS_PENDING_BIT] = cmd_valid;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      local_rdata <= `BYTE_RESET;
    end else if (dma_complete && !dma_req.write) begin
      local_rdata <= dma_rdata;
    end else if (local_read && !window_hit) begin
      local_rdata <= next_rdata;
    end
  end

  // The valid pulse marks one read result per access, whichever path served it.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      local_rvalid <= 1'b0;
    end else if (dma_complete) begin
      local_rvalid <= !dma_req.write;
    end else begin
      local_rvalid <= local_read && !window_hit;
    end
  end

  // Each decoded range has its own comparator pair; the window half selects nothing.
  for (genvar r = 0; r < 5; r++) begin : g_range
    logic in_range;
    assign in_range = (local_addr >= RANGE_FIRST[r]) && (local_addr <= RANGE_LAST[r]);
    assign range_hit[4 - r] = local_access && !window_hit && in_range;
  end

  assign sel = local_selects_t'(range_hit);

  assign rom_select = sel.rom;
  assign ram_select = sel.ram;
  assign ext_select_a = sel.ext_a;
  assign ext_select_b = sel.ext_b;
  assign ext_select_c = sel.ext_c;

  // An isolated I/O cycle from local firmware is latched as a fault.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      io_fault <= 1'b0;
    end else if (local_io_cycle) begin
      io_fault <= 1'b1;
    end
  end

endmodule : host_command_port_dma_window

// *** host_bus_model.sv ***
`timescale 1ns/1ps
module host_bus_model (
  input logic clock,
  input logic nrst,
  input logic host_hold_req,
  input logic dma_read,
  input logic dma_write,
  input logic [15:0] dma_addr,
  output logic host_hold_ack,
  output logic dma_done,
  output logic [7:0] dma_rdata
);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      host_hold_ack <= 1'b0;
      dma_done <= 1'b0;
    end else begin
      host_hold_ack <= host_hold_req;
      dma_done <= (dma_read || dma_write) && !dma_done;
    end
  end
  // Outside a read cycle the data bus shows the inverse pattern.
  assign dma_rdata = dma_read ? (dma_addr[7:0] ^ 8'h5A) : ~(dma_addr[7:0] ^ 8'h5A);
endmodule : host_bus_model

// *** host_bridge_sva.sv ***
`timescale 1ns/1ps
module host_bridge_sva (
  input logic clock,
  input logic nrst,
  input logic [7:0] port_jumper,
  input logic host_io_write,
  input logic [7:0] host_io_addr,
  input logic host_cmd_ready,
  input logic host_hold_req,
  input logic priority_chain_in,
  input logic priority_chain_out,
  input logic [15:0] dma_addr,
  input logic dma_read,
  input logic dma_write,
  input logic dma_done,
  input logic upper_window_force,
  input logic [15:0] local_addr,
  input logic local_rd,
  input logic local_wait,
  input logic local_rvalid,
  input logic [7:0] local_rdata,
  input logic ext_select_c,
  input logic local_io_cycle,
  input logic io_fault
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_hold;
    host_io_write && host_io_addr == port_jumper && host_cmd_ready |=> host_hold_req;
  endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  property p_stat;
    local_rd && local_addr == 16'h1800 && host_hold_req && !local_wait |=> local_rdata[0];
  endproperty
  a_stat: assert property (p_stat) else $error("status low");
  property p_rv;
    local_rd && !local_addr[15] && !local_wait |=> local_rvalid;
  endproperty
  a_rv: assert property (p_rv) else $error("no read data");
  property p_addr;
    dma_read || dma_write |-> dma_addr[14:0] == local_addr[14:0];
  endproperty
  a_addr: assert property (p_addr) else $error("dma address");
  property p_b15;
    dma_read || dma_write |-> dma_addr[15] == upper_window_force;
  endproperty
  a_b15: assert property (p_b15) else $error("bit 15");
  property p_win;
    local_rd && local_addr[15] |-> local_wait;
  endproperty
  a_win: assert property (p_win) else $error("no wait");
  property p_one;
    dma_done && (dma_read || dma_write) |=> !dma_read && !dma_write;
  endproperty
  a_one: assert property (p_one) else $error("long dma");
  property p_sel;
    local_rd |-> ext_select_c == (local_addr inside {[16'h1C00:16'h1FFF]});
  endproperty
  a_sel: assert property (p_sel) else $error("select");
  property p_io;
    local_io_cycle |=> io_fault;
  endproperty
  a_io: assert property (p_io) else $error("io fault");
  property p_pri;
    !priority_chain_in |-> !priority_chain_out;
  endproperty
  a_pri: assert property (p_pri) else $error("priority");
  c_hold: cover property (host_hold_req && local_rvalid);
  c_dma: cover property (dma_read && dma_done);
  c_full: cover property (!host_cmd_ready);
endmodule : host_bridge_sva
bind host_command_port_dma_window host_bridge_sva chk (.*);

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h", $time, a); end end
module testbench;
  logic clock = 0, nrst = 0, host_io_write = 0, local_rd = 0, local_wr = 0, local_fetch = 0;
  logic upper_window_force = 0, priority_chain_in = 1, local_io_cycle = 0, host_hold_ack;
  logic dma_done, host_cmd_ready, host_hold_req, priority_chain_out, dma_data_oe, dma_read;
  logic dma_write, local_rvalid, local_wait, rom_select, ram_select, ext_select_a;
  logic ext_select_b, ext_select_c, io_fault, dw;
  logic [7:0] port_jumper = 8'hFD, host_io_addr = 8'h00, host_data_out = 8'h00;
  logic [7:0] local_wdata = 8'h00, dma_wdata, dma_rdata, local_rdata, rd8, wd, i;
  logic [15:0] dma_addr, local_addr = 16'h0000, seen;
  logic [15:0] sa [6] = '{16'h07FF, 16'h0800, 16'h0A00, 16'h0C00, 16'h13FF, 16'h1C00};
  logic [4:0] se [6] = '{5'h10, 5'h08, 5'h00, 5'h04, 5'h02, 5'h01};
  int fail_count = 0, cmp_count = 0;
  always #12.5 clock = ~clock;
  host_command_port_dma_window DUT (.*);
  host_bus_model host (.*);
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task host_cmd(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    host_io_write = 1;
    host_io_addr = a;
    host_data_out = d;
    @(negedge clock);
    host_io_write = 0;
  endtask : host_cmd
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(negedge clock);
    local_addr = a;
    local_wdata = d;
    local_rd = !w && !local_fetch;
    local_wr = w;
    dw = 0;
    for (n = 0; n < 40; n++) begin
      @(negedge clock);
      if (local_rvalid || (dw && !dma_write)) break;
      if (a[15]) `CHK(local_wait, 1'b1)
      if (dma_write) `CHK(dma_data_oe, 1'b1)
      if (dma_read) `CHK(dma_data_oe, 1'b0)
      if (dma_read || dma_write) seen = dma_addr;
      if (dma_write) wd = dma_wdata;
      dw = dma_write;
    end
    if (n == 40) begin
      fail_count++;
      stop_test();
    end
    rd8 = local_rdata;
    local_rd = 0;
    local_wr = 0;
  endtask : acc
  initial begin
    repeat (5) @(negedge clock);
    nrst = 1;
    acc(0, 16'h1800, 8'h00);
    `CHK(rd8[0], 1'b0)
    host_cmd(8'hFE, 8'h11);
    `CHK(host_hold_req, 1'b0)
    host_cmd(8'hFD, 8'h3C);
    `CHK(host_hold_req, 1'b1)
    acc(0, 16'h1800, 8'h00);
    `CHK(rd8[0], 1'b1)
    acc(0, 16'h1400, 8'h00);
    `CHK(rd8, 8'h3C)
    `CHK(host_hold_req, 1'b0)
    $display("command test ends");
    for (i = 8'h00; i < 8'h09; i++) host_cmd(8'hFD, 8'h40 + i);
    `CHK(host_cmd_ready, 1'b0)
    for (i = 8'h00; i < 8'h08; i++) begin
      acc(0, 16'h1400, 8'h00);
      `CHK(rd8, 8'h40 + i)
    end
    `CHK(host_hold_req, 1'b0)
    $display("queue test ends");
    acc(0, 16'h92FF, 8'h00);
    `CHK(seen, 16'h12FF)
    `CHK(rd8, 8'hA5)
    upper_window_force = 1;
    local_fetch = 1;
    acc(0, 16'h92FF, 8'h00);
    `CHK(seen, 16'h92FF)
    `CHK(rd8, 8'hA5)
    upper_window_force = 0;
    local_fetch = 0;
    acc(1, 16'h8100, 8'h77);
    `CHK(seen, 16'h0100)
    `CHK(wd, 8'h77)
    host_cmd(8'hFD, 8'h55);
    acc(0, 16'h8001, 8'h00);
    `CHK(host_hold_req, 1'b1)
    `CHK(rd8, 8'h5B)
    acc(0, 16'h1400, 8'h00);
    `CHK(rd8, 8'h55)
    `CHK(host_hold_req, 1'b0)
    $display("window test ends");
    for (int k = 0; k < 6; k++) begin
      @(negedge clock);
      local_addr = sa[k];
      local_rd = 1;
      #1 `CHK({rom_select, ram_select, ext_select_a, ext_select_b, ext_select_c}, se[k])
    end
    @(negedge clock);
    local_rd = 0;
    local_io_cycle = 1;
    @(negedge clock);
    local_io_cycle = 0;
    `CHK(io_fault, 1'b1)
    `CHK(priority_chain_out, 1'b1)
    priority_chain_in = 0;
    #1 `CHK(priority_chain_out, 1'b0)
    $display("decode test ends");
    stop_test();
  end
endmodule : testbench
